// File: include/asfp_defs.svh
// timing counts and sizes for the async slave fifo port
`ifndef ASFP_DEFS_SVH
`define ASFP_DEFS_SVH
`define ASFP_DATA_W          16
`define ASFP_ADDR_W          2
`define ASFP_DEPTH           16
`define ASFP_PARTIAL         8
`define ASFP_CLK_NS          20
`define ASFP_CEIL_CYC(ns)    ((((ns) + `ASFP_CLK_NS - 1) / `ASFP_CLK_NS) < 1 ? 1 : (((ns) + `ASFP_CLK_NS - 1) / `ASFP_CLK_NS))
`define ASFP_FLOOR_CYC(ns)   (((ns) / `ASFP_CLK_NS) < 1 ? 1 : ((ns) / `ASFP_CLK_NS))
`define ASFP_ADDR_SETUP_NS   7
`define ASFP_STB_LOW_NS      20
`define ASFP_STB_HIGH_NS     10
`define ASFP_COMMIT_LAG_NS   2
`define ASFP_WR_FLAG_NS      35
`define ASFP_RD_DATA_NS      25
`define ASFP_SETUP_CYC       `ASFP_CEIL_CYC(`ASFP_ADDR_SETUP_NS)
`define ASFP_HIGH_CYC        `ASFP_CEIL_CYC(`ASFP_STB_HIGH_NS)
`define ASFP_LAG_CYC         `ASFP_CEIL_CYC(`ASFP_COMMIT_LAG_NS)
`define ASFP_WR_FLAG_CYC     `ASFP_FLOOR_CYC(`ASFP_WR_FLAG_NS)
`define ASFP_RD_DATA_CYC     `ASFP_FLOOR_CYC(`ASFP_RD_DATA_NS)
`define ASFP_SYNC_MARGIN_CYC 8
`define ASFP_RST_PTR         0
`endif

// File: include/asfp_pkg.sv
// types for the master end and the device end of the async slave fifo port
package asfp_pkg;
  typedef enum logic [1:0] {
    ASFP_FLAG_EMPTY   = 2'b00,
    ASFP_FLAG_FULL    = 2'b01,
    ASFP_FLAG_PARTIAL = 2'b10
  } asfp_flag_mode_t;

  typedef enum logic [1:0] {
    ASFP_CMD_WRITE     = 2'b00,
    ASFP_CMD_READ      = 2'b01,
    ASFP_CMD_WRITE_END = 2'b10,
    ASFP_CMD_ZLP       = 2'b11
  } asfp_cmd_t;

  typedef enum logic [2:0] {
    ASFP_ST_IDLE    = 3'b000,
    ASFP_ST_SETUP   = 3'b001,
    ASFP_ST_STROBE  = 3'b010,
    ASFP_ST_RELEASE = 3'b011,
    ASFP_ST_GAP     = 3'b100
  } asfp_state_t;
endpackage

// File: include/asfp_if.sv
// pins between the external master and the fifo port device
`timescale 1ns/1ps
`default_nettype none
interface asfp_if #(
  parameter int DW = 16,
  parameter int AW = 2
);
  logic          port_select_n;
  logic          bus_drive_enable_n;
  logic          read_strobe_n;
  logic          write_strobe_n;
  logic          packet_commit_n;
  logic [AW-1:0] fifo_select;
  logic [DW-1:0] m_data;
  logic          m_data_oe_n;
  logic [DW-1:0] d_data;
  logic          d_data_oe_n;
  logic          flag_fixed;
  logic          flag_current;
  logic [DW-1:0] bus;

  // wire level: device wins a clash; an undriven bus shows the inverse so stale samples show up
  assign bus = !d_data_oe_n ? d_data : (!m_data_oe_n ? m_data : ~m_data);

  modport device (
    input  port_select_n, bus_drive_enable_n, read_strobe_n, write_strobe_n,
    input  packet_commit_n, fifo_select, bus, m_data_oe_n,
    output d_data, d_data_oe_n, flag_fixed, flag_current
  );
  modport master (
    output port_select_n, bus_drive_enable_n, read_strobe_n, write_strobe_n,
    output packet_commit_n, fifo_select, m_data, m_data_oe_n,
    input  bus, d_data_oe_n, flag_fixed, flag_current
  );
endinterface
`default_nettype wire

// File: src/asfp_sync.sv
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module asfp_sync
  import asfp_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } asfp_sync_st_t;

  asfp_sync_st_t r;
  asfp_sync_st_t nxt;

  // the first stage feeds only the second
  always_comb begin
    nxt.meta   = i_async;
    nxt.stable = r.meta;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= {RST, RST};
    end else begin
      r <= nxt;
    end
  end

  assign o_sync = r.stable;
endmodule
`default_nettype wire

// File: src/asfp_device.sv
// device end: fifo storage, strobe edge handling, data drive and flags
`timescale 1ns/1ps
`default_nettype none
`include "asfp_defs.svh"
// How it works
// RULE_01: select plus enable low drives the bus
// RULE_02: show new fifo only after read strobe
// RULE_03: read pointer steps on read strobe release
// RULE_04: enable and read strobe may be tied
// RULE_05: master sets address before write strobe
// RULE_06: write strobe release stores word, steps pointer
// RULE_07: master holds data through strobe release
// RULE_08: flag follows fill level after write
// RULE_09: commit line with last word ends packet
// RULE_10: address steady while commit line low
// RULE_11: commit without write strobe is empty packet
// RULE_12: flags show empty, full or partial
// RULE_13: commit released after write strobe release
// RULE_14: commit asserted together with write strobe
// RULE_15: strobes synchronised, one edge one step
module asfp_device
  import asfp_pkg::*;
#(
  parameter int DW      = `ASFP_DATA_W,
  parameter int AW      = `ASFP_ADDR_W,
  parameter int DEPTH   = `ASFP_DEPTH,
  parameter int PARTIAL = `ASFP_PARTIAL
) (
  // clock and reset
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_n,
  // link
  asfp_if.device               lnk,
  // flag configuration
  input  wire asfp_flag_mode_t i_flag_mode,
  input  wire logic            i_flag_track_current,
  input  wire logic [AW-1:0]   i_flag_fixed_sel,
  // usb side access to the fifos
  input  wire logic            i_usb_push,
  input  wire logic            i_usb_pop,
  input  wire logic [AW-1:0]   i_usb_fifo,
  input  wire logic [DW-1:0]   i_usb_data,
  output logic                 o_usb_ack,
  output logic      [DW-1:0]   o_usb_head,
  // packet commit events
  output logic                 o_pkt_done,
  output logic                 o_pkt_zlp,
  output logic      [AW-1:0]   o_pkt_fifo
);
  localparam int NF = 1 << AW;
  localparam int PW = $clog2(DEPTH);
  localparam int SW = 5 + AW + DW;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW:0] PART_CNT = (PW + 1)'(PARTIAL);

  typedef struct packed {
    logic [NF-1:0][DEPTH-1:0][DW-1:0] mem;
    logic [NF-1:0][PW-1:0]            rdp;
    logic [NF-1:0][PW-1:0]            wrp;
    logic [NF-1:0][PW:0]              cnt;
    logic                             rd_prev;
    logic                             wr_prev;
    logic                             pe_prev;
    logic [DW-1:0]                    data_prev;
    logic [AW-1:0]                    shown_sel;
    logic [DW-1:0]                    rd_data;
    logic                             drive_n;
    logic                             flag_f;
    logic                             flag_c;
    logic                             pkt_done;
    logic                             pkt_zlp;
    logic [AW-1:0]                    pkt_fifo;
    logic                             usb_ack;
    logic [DW-1:0]                    usb_head;
  } asfp_dev_st_t;

  asfp_dev_st_t        r;
  asfp_dev_st_t        nxt;
  logic [SW-1:0]       pins;
  logic [SW-1:0]       spins;
  logic                s_cs_n;
  logic                s_oe_n;
  logic                s_rd_n;
  logic                s_wr_n;
  logic                s_pe_n;
  logic [AW-1:0]       s_sel;
  logic [DW-1:0]       s_data;

  assign pins = {lnk.port_select_n, lnk.bus_drive_enable_n, lnk.read_strobe_n,
                 lnk.write_strobe_n, lnk.packet_commit_n, lnk.fifo_select, lnk.bus};

  // RULE_15 pin synchroniser
  asfp_sync #(
    .W   (SW),
    .RST ({5'h1f, {(AW + DW){1'b0}}})
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (pins),
    .o_sync    (spins)
  );

  assign {s_cs_n, s_oe_n, s_rd_n, s_wr_n, s_pe_n, s_sel, s_data} = spins;

  always_comb begin
    logic          rd_rise;
    logic          rd_fall;
    logic          wr_rise;
    logic          pe_fall;
    logic          m_pop;
    logic          m_push;
    logic          u_pop;
    logic          u_push;
    logic [AW-1:0] fsel;
    logic [PW:0]   fcnt;
    rd_rise = 1'b0;
    rd_fall = 1'b0;
    wr_rise = 1'b0;
    pe_fall = 1'b0;
    m_pop   = 1'b0;
    m_push  = 1'b0;
    u_pop   = 1'b0;
    u_push  = 1'b0;
    fsel    = '0;
    fcnt    = '0;
    nxt     = r;
    nxt.pkt_done = 1'b0;
    nxt.pkt_zlp  = 1'b0;
    nxt.usb_ack  = 1'b0;
    // RULE_15 one edge per pulse
    rd_rise = !r.rd_prev && s_rd_n && !s_cs_n;
    rd_fall = r.rd_prev && !s_rd_n && !s_cs_n;
    wr_rise = !r.wr_prev && s_wr_n && !s_cs_n;
    pe_fall = r.pe_prev && !s_pe_n && !s_cs_n;
    nxt.rd_prev   = s_rd_n;
    nxt.wr_prev   = s_wr_n;
    nxt.pe_prev   = s_pe_n;
    // word seen while the strobe was still low, the release sample may be stale
    nxt.data_prev = s_data;
    // RULE_01 drive when selected and enabled
    // RULE_04 select and enable alone decide drive, so a tied strobe is harmless
    nxt.drive_n = s_cs_n || s_oe_n;
    // RULE_02 previous fifo until read strobe
    if (rd_fall) begin
      nxt.shown_sel = s_sel;
    end
    nxt.rd_data = r.mem[r.shown_sel][r.rdp[r.shown_sel]];
    // RULE_03 pop on strobe release
    m_pop  = rd_rise && (r.cnt[s_sel] != '0);
    // RULE_06 store on strobe release
    m_push = wr_rise && (r.cnt[s_sel] != FULL_CNT);
    // master wins; usb access to the same fifo in that cycle is refused
    if (!((rd_rise || wr_rise) && (s_sel == i_usb_fifo))) begin
      u_pop  = i_usb_pop && (r.cnt[i_usb_fifo] != '0);
      u_push = i_usb_push && !i_usb_pop && (r.cnt[i_usb_fifo] != FULL_CNT);
    end
    if (m_push) begin
      nxt.mem[s_sel][r.wrp[s_sel]] = r.data_prev;
      nxt.wrp[s_sel] = r.wrp[s_sel] + 1'b1;
      nxt.cnt[s_sel] = r.cnt[s_sel] + 1'b1;
    end
    if (m_pop) begin
      nxt.rdp[s_sel] = r.rdp[s_sel] + 1'b1;
      nxt.cnt[s_sel] = r.cnt[s_sel] - 1'b1;
    end
    if (u_push) begin
      nxt.mem[i_usb_fifo][r.wrp[i_usb_fifo]] = i_usb_data;
      nxt.wrp[i_usb_fifo] = r.wrp[i_usb_fifo] + 1'b1;
      nxt.cnt[i_usb_fifo] = r.cnt[i_usb_fifo] + 1'b1;
    end
    if (u_pop) begin
      nxt.usb_head = r.mem[i_usb_fifo][r.rdp[i_usb_fifo]];
      nxt.rdp[i_usb_fifo] = r.rdp[i_usb_fifo] + 1'b1;
      nxt.cnt[i_usb_fifo] = r.cnt[i_usb_fifo] - 1'b1;
    end
    nxt.usb_ack = u_pop || u_push;
    // RULE_09 last word with commit low
    if (wr_rise && !s_pe_n) begin
      nxt.pkt_done = 1'b1;
      nxt.pkt_fifo = s_sel;
    end
    // RULE_11 commit with no write strobe
    if (pe_fall && s_wr_n) begin
      nxt.pkt_done = 1'b1;
      nxt.pkt_zlp  = 1'b1;
      nxt.pkt_fifo = s_sel;
    end
    // RULE_12 fixed flag from chosen fifo
    // RULE_08 flags use the new fill level
    for (int k = 0; k < 2; k++) begin
      fsel = (k == 1 && i_flag_track_current) ? s_sel : i_flag_fixed_sel;
      fcnt = nxt.cnt[fsel];
      if (k == 0) begin
        fsel = i_flag_fixed_sel;
        fcnt = nxt.cnt[fsel];
      end
      unique case (i_flag_mode)
        ASFP_FLAG_EMPTY:   fcnt = {(PW + 1){fcnt == '0}};
        ASFP_FLAG_FULL:    fcnt = {(PW + 1){fcnt == FULL_CNT}};
        ASFP_FLAG_PARTIAL: fcnt = {(PW + 1){fcnt >= PART_CNT}};
        default:           fcnt = '0;
      endcase
      if (k == 0) begin
        nxt.flag_f = fcnt[0];
      end else begin
        nxt.flag_c = fcnt[0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r         <= '0;
      r.rd_prev <= 1'b1;
      r.wr_prev <= 1'b1;
      r.pe_prev <= 1'b1;
      r.drive_n <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  assign lnk.d_data       = r.rd_data;
  assign lnk.d_data_oe_n  = r.drive_n;
  assign lnk.flag_fixed   = r.flag_f;
  assign lnk.flag_current = r.flag_c;
  assign o_usb_ack        = r.usb_ack;
  assign o_usb_head       = r.usb_head;
  assign o_pkt_done       = r.pkt_done;
  assign o_pkt_zlp        = r.pkt_zlp;
  assign o_pkt_fifo       = r.pkt_fifo;
endmodule
`default_nettype wire

// File: src/asfp_master.sv
// master end: turns user commands into strobe sequences on the port
`timescale 1ns/1ps
`default_nettype none
`include "asfp_defs.svh"
module asfp_master
  import asfp_pkg::*;
#(
  parameter int DW       = `ASFP_DATA_W,
  parameter int AW       = `ASFP_ADDR_W,
  parameter int LOW_CYC  = `ASFP_SYNC_MARGIN_CYC,
  parameter int HIGH_CYC = `ASFP_HIGH_CYC
) (
  // clock and reset
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst_n,
  // link
  asfp_if.master             lnk,
  // command
  input  wire logic          i_cmd_valid,
  input  wire asfp_cmd_t     i_cmd_kind,
  input  wire logic [AW-1:0] i_cmd_fifo,
  input  wire logic [DW-1:0] i_cmd_data,
  output logic               o_cmd_ready,
  // answer and flags
  output logic               o_rsp_valid,
  output logic      [DW-1:0] o_rsp_data,
  output logic               o_flag_fixed,
  output logic               o_flag_current
);
  localparam logic [3:0] SETUP_N = 4'(`ASFP_SETUP_CYC - 1);
  localparam logic [3:0] LOW_N   = 4'(LOW_CYC - 1);
  localparam logic [3:0] LAG_N   = 4'(`ASFP_LAG_CYC - 1);
  localparam logic [3:0] HIGH_N  = 4'(HIGH_CYC - 1);

  typedef struct packed {
    asfp_state_t   st;
    logic [3:0]    cnt;
    asfp_cmd_t     kind;
    logic [AW-1:0] fifo;
    logic [DW-1:0] data;
    logic          cs_n;
    logic          oe_n;
    logic          rd_n;
    logic          wr_n;
    logic          pe_n;
    logic          dat_oe_n;
    logic          ready;
    logic          rsp_valid;
    logic [DW-1:0] rsp_data;
    logic          flag_f;
    logic          flag_c;
  } asfp_mst_st_t;

  asfp_mst_st_t    r;
  asfp_mst_st_t    nxt;
  logic [DW+1:0]   spins;

  // bus and flags come from another clock domain
  asfp_sync #(
    .W   (DW + 2),
    .RST ('0)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({lnk.flag_fixed, lnk.flag_current, lnk.bus}),
    .o_sync    (spins)
  );

  always_comb begin
    nxt           = r;
    nxt.rsp_valid = 1'b0;
    nxt.flag_f    = spins[DW+1];
    nxt.flag_c    = spins[DW];
    if (r.cnt != '0) begin
      nxt.cnt = r.cnt - 1'b1;
    end
    unique case (r.st)
      ASFP_ST_IDLE: begin
        if (i_cmd_valid && r.ready) begin
          // RULE_05 address and select before strobe
          nxt.ready    = 1'b0;
          nxt.kind     = i_cmd_kind;
          nxt.fifo     = i_cmd_fifo;
          nxt.data     = i_cmd_data;
          nxt.cs_n     = 1'b0;
          nxt.dat_oe_n = (i_cmd_kind == ASFP_CMD_READ) || (i_cmd_kind == ASFP_CMD_ZLP);
          nxt.cnt      = SETUP_N;
          nxt.st       = ASFP_ST_SETUP;
        end
      end
      ASFP_ST_SETUP: begin
        if (r.cnt == '0) begin
          nxt.rd_n = (r.kind != ASFP_CMD_READ);
          // RULE_04 enable tied to the read strobe
          nxt.oe_n = nxt.rd_n;
          nxt.wr_n = (r.kind == ASFP_CMD_READ) || (r.kind == ASFP_CMD_ZLP);
          // RULE_14 commit with the write strobe
          nxt.pe_n = !((r.kind == ASFP_CMD_WRITE_END) || (r.kind == ASFP_CMD_ZLP));
          nxt.cnt  = LOW_N;
          nxt.st   = ASFP_ST_STROBE;
        end
      end
      ASFP_ST_STROBE: begin
        if (r.cnt == '0) begin
          if (r.kind == ASFP_CMD_READ) begin
            nxt.rsp_valid = 1'b1;
            nxt.rsp_data  = spins[DW-1:0];
          end
          // RULE_07 data stays until the gap ends
          nxt.rd_n = 1'b1;
          nxt.oe_n = 1'b1;
          nxt.wr_n = 1'b1;
          if (r.kind == ASFP_CMD_ZLP) begin
            nxt.pe_n = 1'b1;
          end
          nxt.cnt = LAG_N;
          nxt.st  = ASFP_ST_RELEASE;
        end
      end
      ASFP_ST_RELEASE: begin
        // RULE_13 commit trails write strobe
        if (r.cnt == '0) begin
          nxt.pe_n = 1'b1;
          nxt.cnt  = HIGH_N;
          nxt.st   = ASFP_ST_GAP;
        end
      end
      ASFP_ST_GAP: begin
        // RULE_10 address held past commit release
        if (r.cnt == '0) begin
          nxt.cs_n     = 1'b1;
          nxt.oe_n     = 1'b1;
          nxt.dat_oe_n = 1'b1;
          nxt.ready    = 1'b1;
          nxt.st       = ASFP_ST_IDLE;
        end
      end
      default: begin
        nxt.st    = ASFP_ST_IDLE;
        nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r          <= '0;
      r.st       <= ASFP_ST_IDLE;
      r.cs_n     <= 1'b1;
      r.oe_n     <= 1'b1;
      r.rd_n     <= 1'b1;
      r.wr_n     <= 1'b1;
      r.pe_n     <= 1'b1;
      r.dat_oe_n <= 1'b1;
      r.ready    <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  assign lnk.port_select_n      = r.cs_n;
  assign lnk.bus_drive_enable_n = r.oe_n;
  assign lnk.read_strobe_n      = r.rd_n;
  assign lnk.write_strobe_n     = r.wr_n;
  assign lnk.packet_commit_n    = r.pe_n;
  assign lnk.fifo_select        = r.fifo;
  assign lnk.m_data             = r.data;
  assign lnk.m_data_oe_n        = r.dat_oe_n;
  assign o_cmd_ready            = r.ready;
  assign o_rsp_valid            = r.rsp_valid;
  assign o_rsp_data             = r.rsp_data;
  assign o_flag_fixed           = r.flag_f;
  assign o_flag_current         = r.flag_c;
endmodule
`default_nettype wire

// File: test/asfp_monitor.sv
// assertions on the pins between the master end and the device end
`timescale 1ns/1ps
`default_nettype none
module asfp_monitor
  import asfp_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 2
) (
  // clock and reset
  input wire logic          i_sys_clk,
  input wire logic          i_rst_n,
  // link pins
  input wire logic          port_select_n,
  input wire logic          bus_drive_enable_n,
  input wire logic          read_strobe_n,
  input wire logic          write_strobe_n,
  input wire logic          packet_commit_n,
  input wire logic [AW-1:0] fifo_select,
  input wire logic [DW-1:0] m_data,
  input wire logic          m_data_oe_n,
  input wire logic          d_data_oe_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // slack of one cycle over the three sync edges
  chk_drive_on: assert property ((!port_select_n && !bus_drive_enable_n)[*5] |-> !d_data_oe_n)
    else $error("device not driving with select and enable low");
  chk_drive_off: assert property ((port_select_n || bus_drive_enable_n)[*5] |-> d_data_oe_n)
    else $error("device still driving after release");
  chk_drive_cause: assert property ($fell(d_data_oe_n) |-> !$past(bus_drive_enable_n, 2) && !$past(port_select_n, 2))
    else $error("device drive without enable");
  chk_oe_tied: assert property (bus_drive_enable_n == read_strobe_n)
    else $error("output enable and read strobe not tied");
  chk_addr_setup: assert property ($fell(write_strobe_n) |-> $past(!port_select_n) && $stable(fifo_select))
    else $error("address or select late for write strobe");
  chk_data_hold: assert property ($rose(write_strobe_n) |-> !m_data_oe_n && $stable(m_data))
    else $error("write data not held through strobe release");
  chk_addr_commit: assert property (!packet_commit_n && $past(!packet_commit_n) |-> $stable(fifo_select))
    else $error("address moved during commit");
  chk_commit_lag: assert property ($rose(packet_commit_n) |-> write_strobe_n && $past(write_strobe_n))
    else $error("commit released before write strobe");
  chk_commit_with_wr: assert property ($fell(packet_commit_n) && !write_strobe_n |-> $fell(write_strobe_n))
    else $error("commit and write strobe not asserted together");
  // the low phase must outlast the two flop synchroniser
  chk_strobe_width: assert property ($fell(write_strobe_n) |-> (!write_strobe_n)[*8])
    else $error("write strobe pulse too short");
endmodule
`default_nettype wire

// File: test/async_slave_fifo_port_tb.sv
// bench: master and device ends joined, fifo contents modelled with queues
`timescale 1ns/1ps
`default_nettype none
`include "asfp_defs.svh"
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module async_slave_fifo_port_tb
  import asfp_pkg::*;
;
  localparam int DW = 16;
  localparam int AW = 2;
  logic            i_sys_clk;
  logic            i_rst_n;
  logic            cmd_valid;
  asfp_cmd_t       cmd_kind;
  logic [AW-1:0]   cmd_fifo;
  logic [DW-1:0]   cmd_data;
  logic            cmd_ready;
  logic            rsp_valid;
  logic [DW-1:0]   rsp_data;
  logic            m_flag_fix;
  logic            m_flag_cur;
  asfp_flag_mode_t flag_mode;
  logic            track;
  logic [AW-1:0]   fixed_sel;
  logic            usb_push;
  logic            usb_pop;
  logic [AW-1:0]   usb_fifo;
  logic [DW-1:0]   usb_data;
  logic            usb_ack;
  logic [DW-1:0]   usb_head;
  logic            pkt_done;
  logic            pkt_zlp;
  logic [AW-1:0]   pkt_fifo;
  logic [DW-1:0]   q[4][$];
  int              fail_count;
  int              checks_done;
  int              pkt_seen;
  int              rsp_seen;
  logic            pkt_z;
  logic [AW-1:0]   pkt_f;
  logic [DW-1:0]   rsp_d;

  asfp_if #(.DW(DW), .AW(AW)) lnk ();
  asfp_device u_asfp_device (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .lnk(lnk), .i_flag_mode(flag_mode),
    .i_flag_track_current(track), .i_flag_fixed_sel(fixed_sel), .i_usb_push(usb_push), .i_usb_pop(usb_pop),
    .i_usb_fifo(usb_fifo), .i_usb_data(usb_data), .o_usb_ack(usb_ack), .o_usb_head(usb_head),
    .o_pkt_done(pkt_done), .o_pkt_zlp(pkt_zlp), .o_pkt_fifo(pkt_fifo));
  asfp_master u_asfp_master (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .lnk(lnk), .i_cmd_valid(cmd_valid),
    .i_cmd_kind(cmd_kind), .i_cmd_fifo(cmd_fifo), .i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_flag_fixed(m_flag_fix), .o_flag_current(m_flag_cur));
  asfp_monitor #(.DW(DW), .AW(AW)) u_asfp_monitor (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .port_select_n(lnk.port_select_n), .bus_drive_enable_n(lnk.bus_drive_enable_n),
    .read_strobe_n(lnk.read_strobe_n), .write_strobe_n(lnk.write_strobe_n),
    .packet_commit_n(lnk.packet_commit_n), .fifo_select(lnk.fifo_select), .m_data(lnk.m_data),
    .m_data_oe_n(lnk.m_data_oe_n), .d_data_oe_n(lnk.d_data_oe_n));

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // pulses are caught here so no task can miss one
  always @(posedge i_sys_clk) begin
    if (pkt_done === 1'b1) begin
      pkt_seen++;
      pkt_z = pkt_zlp;
      pkt_f = pkt_fifo;
    end
    if (rsp_valid === 1'b1) begin
      rsp_seen++;
      rsp_d = rsp_data;
    end
  end

  function automatic logic flag_exp(input int n, input asfp_flag_mode_t m);
    case (m)
      ASFP_FLAG_EMPTY:   return n == 0;
      ASFP_FLAG_FULL:    return n == `ASFP_DEPTH;
      ASFP_FLAG_PARTIAL: return n >= `ASFP_PARTIAL;
      default:           return 1'b0;
    endcase
  endfunction

  task automatic end_sim();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_cmd(input asfp_cmd_t k, input logic [AW-1:0] f, input logic [DW-1:0] d);
    int            n;
    int            p0;
    int            r0;
    logic          have;
    logic [DW-1:0] e;
    p0 = pkt_seen;
    r0 = rsp_seen;
    have = q[f].size() > 0;
    e = have ? q[f][0] : '0;
    @(negedge i_sys_clk);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_fifo = f;
    cmd_data = d;
    @(negedge i_sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge i_sys_clk);
      n++;
    end
    `CHK(n < 100, 1'b1, "command never finished")
    // flags pass the device sync and then the master sync
    repeat (10) @(negedge i_sys_clk);
    if (k == ASFP_CMD_READ) begin
      `CHK(rsp_seen - r0, 1, "read answer count")
      if (have) begin
        `CHK(rsp_d, e, "read data")
        void'(q[f].pop_front());
      end
    end else if (k == ASFP_CMD_ZLP) begin
      `CHK(pkt_seen - p0, 1, "empty packet count")
      `CHK({pkt_z, pkt_f}, {1'b1, f}, "empty packet kind")
    end else begin
      // a full fifo refuses the word silently
      if (q[f].size() < `ASFP_DEPTH)
        q[f].push_back(d);
      `CHK(pkt_seen - p0, int'(k == ASFP_CMD_WRITE_END), "commit count")
      if (k == ASFP_CMD_WRITE_END)
        `CHK({pkt_z, pkt_f}, {1'b0, f}, "short packet kind")
    end
    `CHK(m_flag_cur, flag_exp(q[track ? f : fixed_sel].size(), flag_mode), "current flag")
    `CHK(m_flag_fix, flag_exp(q[fixed_sel].size(), flag_mode), "fixed flag")
  endtask

  task automatic usb_op(input logic push, input logic [AW-1:0] f, input logic [DW-1:0] d);
    logic          ok;
    logic          got;
    logic [DW-1:0] e;
    logic [DW-1:0] h;
    ok = push ? q[f].size() < `ASFP_DEPTH : q[f].size() > 0;
    e = (ok && !push) ? q[f][0] : '0;
    h = '0;
    @(negedge i_sys_clk);
    usb_push = push;
    usb_pop = !push;
    usb_fifo = f;
    usb_data = d;
    @(negedge i_sys_clk);
    usb_push = 1'b0;
    usb_pop = 1'b0;
    got = 1'b0;
    repeat (2) begin
      if (usb_ack === 1'b1) begin
        got = 1'b1;
        h = usb_head;
      end
      @(negedge i_sys_clk);
    end
    `CHK(got, ok, "usb side acknowledge")
    if (ok && !push)
      `CHK(h, e, "usb side head word")
    if (ok && push)
      q[f].push_back(d);
    if (ok && !push)
      void'(q[f].pop_front());
  endtask

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    fail_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    i_rst_n = 1'b0;
    {cmd_valid, usb_push, usb_pop, track} = 4'h0;
    cmd_kind = ASFP_CMD_WRITE;
    flag_mode = ASFP_FLAG_EMPTY;
    {cmd_fifo, fixed_sel, usb_fifo} = '0;
    {cmd_data, usb_data} = '0;
    {fail_count, checks_done, pkt_seen, rsp_seen} = '0;
    repeat (12) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    void'($urandom(32'h1695_2840));
    // random mix fills some fifos past full and reads others past empty
    for (int i = 0; i < 120; i++) begin
      flag_mode = asfp_flag_mode_t'(i % 4);
      track = i[2];
      fixed_sel = AW'($urandom_range(3, 0));
      do_cmd(asfp_cmd_t'($urandom_range(3, 0)), AW'($urandom_range(3, 0)), DW'($urandom));
    end
    // usb side fills one fifo until refused, then drains it past empty
    for (int i = 0; i < 18; i++)
      usb_op(1'b1, 2'h3, DW'($urandom));
    do_cmd(ASFP_CMD_READ, 2'h3, 16'h0000);
    for (int i = 0; i < 17; i++)
      usb_op(1'b0, 2'h3, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
